// ===== hw/main_memory_segment_protection.sv
// Main memory segment protection with an AXI4-Lite register slave
// What this block does
// - Block writes to read-only, fetches from data
// - Enable cleared means no restriction at all
// - Reset leaves all memory fully accessible
// - Two five-bit borders give up to three segments
// - Granularity is one page, size over 32
// - Segment one starts at lowest main address
// - Segment three runs to highest main address
// - Compare each address against both borders
// - Equal borders give at most two segments, never segment two
// - Each segment has its own access rights
// - Information memory has separate access rights
// - Configuration writes need the correct key
// - Border field is address bits 13 to 9, the top five bits of the main memory offset
`timescale 1ns/1ps
module main_memory_segment_protection
  import prot_pkg::*;
(
  input  logic                        CLK_SYS_I,
  input  logic                        RST_I,
  // AXI4-Lite write address and data
  input  logic [prot_pkg::AXI_AW-1:0] AWADDR_I,
  input  logic                        AWVALID_I,
  output logic                        AWREADY_O,
  input  logic [31:0]                 WDATA_I,
  input  logic [3:0]                  WSTRB_I,
  input  logic                        WVALID_I,
  output logic                        WREADY_O,
  output logic [1:0]                  BRESP_O,
  output logic                        BVALID_O,
  input  logic                        BREADY_I,
  // AXI4-Lite read
  input  logic [prot_pkg::AXI_AW-1:0] ARADDR_I,
  input  logic                        ARVALID_I,
  output logic                        ARREADY_O,
  output logic [31:0]                 RDATA_O,
  output logic [1:0]                  RRESP_O,
  output logic                        RVALID_O,
  input  logic                        RREADY_I,
  // Memory address bus from the core
  input  logic [prot_pkg::ADDR_W-1:0] MEM_ADDR_I,
  input  logic                        MEM_VALID_I,
  input  prot_pkg::access_t           MEM_KIND_I,
  // Verdict, one cycle after the access
  output logic                        ACCESS_OK_O,
  output logic                        VIOLATION_O,
  output prot_pkg::region_t           SEG_SEL_O
);

  import prot_pkg::*;

  // Configuration and status state
  logic                protection_enable;
  logic [PAGE_W-1:0]   lower_border_page;
  logic [PAGE_W-1:0]   upper_border_page;
  logic [RIGHTS_W-1:0] rights_seg1;
  logic [RIGHTS_W-1:0] rights_seg2;
  logic [RIGHTS_W-1:0] rights_seg3;
  logic [RIGHTS_W-1:0] rights_info;
  logic [3:0]          viol_flags;
  logic                key_error;
  logic [ADDR_W-1:0]   viol_addr;

  // Bus slave state
  logic                aw_held;
  logic                w_held;
  logic [AXI_AW-1:0]   wr_addr;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;

  // Combinational decode
  logic                wr_go;
  logic                wr_cfg;
  logic                wr_key_ok;
  logic                wr_apply;
  logic                wr_bad;
  logic                status_clr;
  region_t             region;
  logic [RIGHTS_W-1:0] sel_rights;
  logic                allow;
  logic [3:0]          viol_set;
  logic [3:0]          next_viol;

  // Rights of one region
  function automatic logic [RIGHTS_W-1:0] rights_for(input region_t r,
      input logic [RIGHTS_W-1:0] s1, input logic [RIGHTS_W-1:0] s2,
      input logic [RIGHTS_W-1:0] s3, input logic [RIGHTS_W-1:0] inf);
    unique case (r)
      RGN_SEG1: rights_for = s1;
      RGN_SEG2: rights_for = s2;
      RGN_SEG3: rights_for = s3;
      RGN_INFO: rights_for = inf;
      default:  rights_for = RIGHTS_RESET;
    endcase
  endfunction : rights_for

  // Mapped offsets
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = (a == OFS_CTL) || (a == OFS_SEG) || (a == OFS_RIGHTS) ||
                (a == OFS_STATUS) || (a == OFS_VADDR);
  endfunction : is_mapped

  // Segment lookup and rights check
  segment_select u_select (
    .addr_i   (MEM_ADDR_I),
    .lower_i  (lower_border_page),
    .upper_i  (upper_border_page),
    .region_o (region)
  );

  assign sel_rights = rights_for(region, rights_seg1, rights_seg2,
                                 rights_seg3, rights_info);

  rights_check u_check (
    .enable_i (protection_enable),
    .kind_i   (MEM_KIND_I),
    .region_i (region),
    .rights_i (sel_rights),
    .allow_o  (allow)
  );

  // Write decode: both halves held and no response pending
  assign wr_go      = aw_held && w_held && !BVALID_O;
  assign wr_cfg     = (wr_addr == OFS_CTL) || (wr_addr == OFS_SEG) ||
                      (wr_addr == OFS_RIGHTS);
  assign wr_key_ok  = wr_data[KEY_LSB +: 8] == KEY_VALUE;
  assign wr_apply   = wr_go && wr_cfg && wr_key_ok &&
                      wr_strb == STRB_FULL;
  assign wr_bad     = !is_mapped(wr_addr) || wr_strb != STRB_FULL ||
                      (wr_cfg && !wr_key_ok);
  assign status_clr = wr_go && wr_addr == OFS_STATUS &&
                      wr_strb == STRB_FULL;

  // Write address channel
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      AWREADY_O <= 1'b0;
      aw_held   <= 1'b0;
      wr_addr   <= '0;
    end else if (AWVALID_I && AWREADY_O) begin
      AWREADY_O <= 1'b0;
      aw_held   <= 1'b1;
      wr_addr   <= AWADDR_I;
    end else if (wr_go) begin
      aw_held   <= 1'b0;
    end else if (!aw_held && !BVALID_O) begin
      AWREADY_O <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      WREADY_O <= 1'b0;
      w_held   <= 1'b0;
      wr_data  <= '0;
      wr_strb  <= '0;
    end else if (WVALID_I && WREADY_O) begin
      WREADY_O <= 1'b0;
      w_held   <= 1'b1;
      wr_data  <= WDATA_I;
      wr_strb  <= WSTRB_I;
    end else if (wr_go) begin
      w_held   <= 1'b0;
    end else if (!w_held && !BVALID_O) begin
      WREADY_O <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= RESP_OKAY;
    end else if (wr_go) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // Enable and borders; reset leaves memory open
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      protection_enable <= 1'b0;
      lower_border_page <= PAGE_RESET;
      upper_border_page <= PAGE_RESET;
    end else if (wr_apply && wr_addr == OFS_CTL) begin
      protection_enable <= wr_data[CTL_EN_BIT];
    end else if (wr_apply && wr_addr == OFS_SEG) begin
      lower_border_page <= wr_data[SEG_LOW_LSB +: PAGE_W];
      upper_border_page <= wr_data[SEG_UP_LSB +: PAGE_W];
    end
  end

  // Access rights per segment and for information memory
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rights_seg1 <= RIGHTS_RESET;
      rights_seg2 <= RIGHTS_RESET;
      rights_seg3 <= RIGHTS_RESET;
      rights_info <= RIGHTS_RESET;
    end else if (wr_apply && wr_addr == OFS_RIGHTS) begin
      rights_seg1 <= wr_data[RT_SEG1_LSB +: RIGHTS_W];
      rights_seg2 <= wr_data[RT_SEG2_LSB +: RIGHTS_W];
      rights_seg3 <= wr_data[RT_SEG3_LSB +: RIGHTS_W];
      rights_info <= wr_data[RT_INFO_LSB +: RIGHTS_W];
    end
  end

  // Sticky violation flags, a new event beats the clear
  always_comb begin
    viol_set = '0;
    if (MEM_VALID_I && !allow) begin
      unique case (region)
        RGN_SEG1: viol_set[0] = 1'b1;
        RGN_SEG2: viol_set[1] = 1'b1;
        RGN_SEG3: viol_set[2] = 1'b1;
        RGN_INFO: viol_set[3] = 1'b1;
        default:  viol_set    = '0;
      endcase
    end
    next_viol = viol_flags;
    if (status_clr) begin
      next_viol = viol_flags & ~wr_data[3:0];
    end
    next_viol = next_viol | viol_set;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      viol_flags <= '0;
    end else begin
      viol_flags <= next_viol;
    end
  end

  // Wrong key sticky flag
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      key_error <= 1'b0;
    end else if (wr_go && wr_cfg && !wr_key_ok) begin
      key_error <= 1'b1;
    end else if (status_clr && wr_data[ST_KEY_BIT]) begin
      key_error <= 1'b0;
    end
  end

  // Address of the latest blocked access
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      viol_addr <= '0;
    end else if (MEM_VALID_I && !allow) begin
      viol_addr <= MEM_ADDR_I;
    end
  end

  // Verdict outputs
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ACCESS_OK_O <= 1'b0;
      VIOLATION_O <= 1'b0;
      SEG_SEL_O   <= RGN_OUTSIDE;
    end else begin
      ACCESS_OK_O <= MEM_VALID_I && allow;
      VIOLATION_O <= MEM_VALID_I && !allow;
      SEG_SEL_O   <= MEM_VALID_I ? region : RGN_OUTSIDE;
    end
  end

  // Read channel
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= '0;
      RRESP_O   <= RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b1;
      RRESP_O   <= is_mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      unique case (ARADDR_I)
        OFS_CTL:    RDATA_O <= {KEY_READBACK, 23'h0, protection_enable};
        OFS_SEG:    RDATA_O <= {19'h0, upper_border_page, 3'h0,
                                lower_border_page};
        OFS_RIGHTS: RDATA_O <= {17'h0, rights_info, 1'b0, rights_seg3,
                                1'b0, rights_seg2, 1'b0, rights_seg1};
        OFS_STATUS: RDATA_O <= {27'h0, key_error, viol_flags};
        OFS_VADDR:  RDATA_O <= {16'h0, viol_addr};
        default:    RDATA_O <= '0;
      endcase
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O  <= 1'b0;
      ARREADY_O <= 1'b1;
    end else if (!RVALID_O) begin
      ARREADY_O <= 1'b1;
    end
  end

  // Checks
  disabled_open_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (!protection_enable && MEM_VALID_I) |=> (ACCESS_OK_O && !VIOLATION_O))
    else $error("access blocked while protection disabled");

  reset_open_a: assert property (@(posedge CLK_SYS_I)
    RST_I |=> (!protection_enable && rights_seg1 == RIGHTS_RESET &&
               rights_info == RIGHTS_RESET))
    else $error("reset did not open memory");

  key_guard_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (wr_go && wr_cfg && !wr_key_ok) |=> ($stable(protection_enable) &&
      $stable(lower_border_page) && $stable(rights_seg2) && key_error))
    else $error("configuration changed without key");

  low_segment_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (MEM_VALID_I && MEM_ADDR_I >= MAIN_BASE &&
     page_of(MEM_ADDR_I) < lower_border_page &&
     page_of(MEM_ADDR_I) < upper_border_page) |=> SEG_SEL_O == RGN_SEG1)
    else $error("low address not in segment one");

  high_segment_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (MEM_VALID_I && MEM_ADDR_I >= MAIN_BASE &&
     page_of(MEM_ADDR_I) == upper_border_page &&
     lower_border_page <= upper_border_page) |=> SEG_SEL_O == RGN_SEG3)
    else $error("upper border page not in segment three");

  two_segments_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (MEM_VALID_I && lower_border_page == upper_border_page)
      |=> SEG_SEL_O != RGN_SEG2)
    else $error("equal borders produced segment two");

  mid_segment_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (MEM_VALID_I && MEM_ADDR_I >= MAIN_BASE &&
     page_of(MEM_ADDR_I) == lower_border_page &&
     lower_border_page < upper_border_page) |=> SEG_SEL_O == RGN_SEG2)
    else $error("lower border page not in segment two");

  write_block_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (MEM_VALID_I && protection_enable && MEM_KIND_I == ACC_WRITE &&
     region == RGN_SEG2 && !rights_seg2[RT_WRITE])
      |=> (VIOLATION_O && viol_flags[1]))
    else $error("write to read-only segment allowed");

  info_fetch_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (MEM_VALID_I && protection_enable && MEM_KIND_I == ACC_FETCH &&
     region == RGN_INFO) |=> (ACCESS_OK_O == $past(rights_info[RT_EXEC])))
    else $error("information memory fetch verdict wrong");

  bresp_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
    else $error("write response dropped early");

endmodule : main_memory_segment_protection

// ===== hw/prot_pkg.sv
// Constants, types and helpers for the segment protection unit
package prot_pkg;

  // Memory address bus and main memory layout
  localparam int          ADDR_W       = 16;
  localparam int          PAGE_W       = 5;
  localparam int          PAGE_LSB     = 9;
  localparam logic [15:0] MAIN_BASE    = 16'hc000;
  localparam logic [15:0] MAIN_LAST    = 16'hffff;
  localparam logic [15:0] INFO_BASE    = 16'h1800;
  localparam logic [15:0] INFO_LAST    = 16'h19ff;

  // Register bus
  localparam int          AXI_AW       = 8;
  localparam logic [7:0]  OFS_CTL      = 8'h00;
  localparam logic [7:0]  OFS_SEG      = 8'h04;
  localparam logic [7:0]  OFS_RIGHTS   = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0c;
  localparam logic [7:0]  OFS_VADDR    = 8'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [3:0]  STRB_FULL    = 4'hf;

  // Key field carried in every configuration write
  localparam int          KEY_LSB      = 24;
  localparam logic [7:0]  KEY_VALUE    = 8'ha5;
  localparam logic [7:0]  KEY_READBACK = 8'h96;
  localparam int          CTL_EN_BIT   = 0;

  // Field positions
  localparam int          SEG_LOW_LSB  = 0;
  localparam int          SEG_UP_LSB   = 8;
  localparam int          RIGHTS_W     = 3;
  localparam int          RT_SEG1_LSB  = 0;
  localparam int          RT_SEG2_LSB  = 4;
  localparam int          RT_SEG3_LSB  = 8;
  localparam int          RT_INFO_LSB  = 12;
  localparam int          RT_READ      = 0;
  localparam int          RT_WRITE     = 1;
  localparam int          RT_EXEC      = 2;
  localparam logic [2:0]  RIGHTS_RESET = 3'h7;
  localparam int          ST_KEY_BIT   = 4;
  localparam logic [4:0]  PAGE_RESET   = 5'h00;

  typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_FETCH} access_t;
  typedef enum logic [2:0] {
    RGN_OUTSIDE, RGN_SEG1, RGN_SEG2, RGN_SEG3, RGN_INFO
  } region_t;

  // Page number of a main memory address
  function automatic logic [PAGE_W-1:0] page_of(input logic [15:0] a);
    logic [15:0] ofs;
    ofs     = a - MAIN_BASE;
    page_of = ofs[PAGE_LSB +: PAGE_W];
  endfunction : page_of

endpackage : prot_pkg

// ===== hw/segment_select.sv
// Maps a memory address onto a main memory segment or information memory
`timescale 1ns/1ps
module segment_select
  import prot_pkg::*;
(
  input  logic [prot_pkg::ADDR_W-1:0] addr_i,
  input  logic [prot_pkg::PAGE_W-1:0] lower_i,
  input  logic [prot_pkg::PAGE_W-1:0] upper_i,
  output prot_pkg::region_t           region_o
);

  logic [PAGE_W-1:0] page;

  assign page = page_of(addr_i);

  // Border address belongs to the segment above it
  always_comb begin
    region_o = RGN_OUTSIDE;
    if (addr_i >= INFO_BASE && addr_i <= INFO_LAST) begin
      region_o = RGN_INFO;
    end else if (addr_i >= MAIN_BASE && addr_i <= MAIN_LAST) begin
      if (page < lower_i && page < upper_i) begin
        region_o = RGN_SEG1;
      end else if (page >= lower_i && page >= upper_i) begin
        region_o = RGN_SEG3;
      end else begin
        region_o = RGN_SEG2;
      end
    end
  end

endmodule : segment_select

// ===== hw/rights_check.sv
// Decides whether one access is allowed under the given rights
`timescale 1ns/1ps
module rights_check
  import prot_pkg::*;
(
  input  logic                          enable_i,
  input  prot_pkg::access_t             kind_i,
  input  prot_pkg::region_t             region_i,
  input  logic [prot_pkg::RIGHTS_W-1:0] rights_i,
  output logic                          allow_o
);

  // Unprotected when disabled or outside the guarded ranges
  always_comb begin
    allow_o = 1'b1;
    if (enable_i && region_i != RGN_OUTSIDE) begin
      unique case (kind_i)
        ACC_READ:  allow_o = rights_i[RT_READ];
        ACC_WRITE: allow_o = rights_i[RT_WRITE];
        ACC_FETCH: allow_o = rights_i[RT_EXEC];
        default:   allow_o = 1'b0;
      endcase
    end
  end

endmodule : rights_check

// ===== verification/core_model.sv
// Processor core model driving the memory address bus
`timescale 1ns/1ps
module core_model
  import prot_pkg::*;
(
  input  logic                        clk_i,
  input  logic                        rst_i,
  output logic [prot_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                        mem_valid_o,
  output prot_pkg::access_t           mem_kind_o
);
  logic [21:0] req_q[$];
  logic [21:0] item;
  logic [3:0]  gap_left;

  // Quiet bus at time zero
  initial begin
    mem_addr_o = 16'h0000;
    mem_valid_o = 1'b0;
    mem_kind_o = ACC_READ;
    gap_left = 4'h0;
  end

  // One access per request, then the requested idle gap
  always @(posedge clk_i) begin
    if (gap_left == 4'h0 && !rst_i && req_q.size() != 0) begin
      item = req_q.pop_front();
      mem_addr_o <= item[21:6];
      mem_kind_o <= access_t'(item[5:4]);
      mem_valid_o <= 1'b1;
      gap_left <= item[3:0];
    end else begin
      // Idle bus never keeps the last address
      if (gap_left != 4'h0) gap_left <= gap_left - 4'h1;
      mem_valid_o <= 1'b0;
      mem_addr_o <= ~mem_addr_o;
      mem_kind_o <= (mem_kind_o == ACC_READ) ? ACC_FETCH : ACC_READ;
    end
  end
endmodule : core_model

// ===== verification/tb.sv
// Self-checking bench for the segment protection unit
`timescale 1ns/1ps
module tb;
  import prot_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ok, viol;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, mon_e;
  logic [1:0]  bresp, rresp;
  logic [15:0] mem_addr;
  logic        mem_valid, en;
  access_t     mem_kind;
  region_t     seg_sel;
  logic [4:0]  lo, up;
  logic [2:0]  rt [4];
  logic [3:0]  exp_q[$];
  logic [15:0] edges [10] = '{16'hc000, 16'hd7ff, 16'hd800, 16'hedff,
    16'hee00, 16'hffff, 16'h1800, 16'h19ff, 16'h1a00, 16'h0200};
  int errors, n_compared, seed;

  main_memory_segment_protection main_memory_segment_protection_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .MEM_ADDR_I(mem_addr), .MEM_VALID_I(mem_valid), .MEM_KIND_I(mem_kind),
    .ACCESS_OK_O(ok), .VIOLATION_O(viol), .SEG_SEL_O(seg_sel));

  core_model core_model_inst (.clk_i(clk), .rst_i(rst),
    .mem_addr_o(mem_addr), .mem_valid_o(mem_valid), .mem_kind_o(mem_kind));

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic hang(input string what);
    errors++;
    $display("MISMATCH %s expected answer seen none", what);
    tally_and_finish();
  endtask : hang

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 64) hang("bvalid");
    check("bresp", 32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 64) hang("rvalid");
    check("rresp", 32'(rresp), 32'(er));
    check("rdata", rdata & m, exp);
    rready <= 1'b0;
  endtask : axi_read

  // Keyed configuration, mirrored in the bench's shadow copy
  task automatic cfg(input logic e, input logic [4:0] l,
                     input logic [4:0] u, input logic [15:0] r);
    axi_write(OFS_SEG, {KEY_VALUE, 11'h0, u, 3'h0, l}, RESP_OKAY);
    axi_write(OFS_RIGHTS, {KEY_VALUE, 8'h00, r}, RESP_OKAY);
    axi_write(OFS_CTL, {KEY_VALUE, 23'h0, e}, RESP_OKAY);
    en = e;
    lo = l;
    up = u;
    rt = '{r[2:0], r[6:4], r[10:8], r[14:12]};
  endtask : cfg

  function automatic logic [3:0] expect_of(input logic [15:0] a,
                                           input access_t k);
    region_t g;
    if (a >= MAIN_BASE) begin
      if (a[13:9] < lo && a[13:9] < up) g = RGN_SEG1;
      else if (a[13:9] >= lo && a[13:9] >= up) g = RGN_SEG3;
      else g = RGN_SEG2;
    end else if (a >= INFO_BASE && a <= INFO_LAST) g = RGN_INFO;
    else g = RGN_OUTSIDE;
    return {!en || g == RGN_OUTSIDE || rt[g - 1][k], g};
  endfunction : expect_of

  task automatic mem_access(input logic [15:0] a, input access_t k,
                            input logic [3:0] gap);
    core_model_inst.req_q.push_back({a, k, gap});
    exp_q.push_back(expect_of(a, k));
  endtask : mem_access

  task automatic drain();
    int n;
    for (n = 0; n < 500; n++) begin
      @(posedge clk);
      if (exp_q.size() == 0) break;
    end
    if (n == 500) hang("verdict");
    repeat (2) @(posedge clk);
  endtask : drain

  task automatic random_mix(input int n);
    logic [31:0] r;
    logic [15:0] a;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      a = r[15:0];
      if (r[17:16] == 2'h0) a = INFO_BASE + {7'h0, r[8:0]};
      if (r[17:16] == 2'h1) a = {2'b11, r[13:0]};
      mem_access(a, (r[19:18] == 2'h3) ? ACC_WRITE : access_t'(r[19:18]),
                 {2'h0, r[21:20]});
    end
    drain();
  endtask : random_mix

  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    en = 1'b0;
    lo = 5'h00;
    up = 5'h00;
    rt = '{3'h7, 3'h7, 3'h7, 3'h7};
    axi_read(OFS_CTL, 32'hff000001, {KEY_READBACK, 24'h0}, RESP_OKAY);
    axi_read(OFS_RIGHTS, 32'h7777, 32'h7777, RESP_OKAY);
    axi_read(OFS_SEG, 32'h1f1f, 32'h0, RESP_OKAY);
    random_mix(24);
  endtask : do_reset

  // Each verdict is matched with the oldest expectation
  always @(negedge clk) begin
    if (ok === 1'b1 || viol === 1'b1) begin
      if (exp_q.size() == 0) check("extra verdict", 32'h1, 32'h0);
      else begin
        mon_e = exp_q.pop_front();
        check("access_ok", 32'(ok), 32'(mon_e[3]));
        check("violation", 32'(viol), 32'(!mon_e[3]));
        check("seg_sel", 32'(seg_sel), 32'(mon_e[2:0]));
      end
    end
  end

  // Main sequence
  initial begin
    seed = 15287;
    errors = 0;
    n_compared = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = STRB_FULL;
    rst = 1'b1;
    do_reset();
    $display("Test reset_state done");
    axi_write(OFS_CTL, 32'h00000001, RESP_SLVERR);
    axi_write(OFS_SEG, 32'h5a001f1f, RESP_SLVERR);
    axi_read(OFS_STATUS, 32'h10, 32'h10, RESP_OKAY);
    axi_write(8'h20, 32'h0, RESP_SLVERR);
    axi_read(8'h20, 32'h0, 32'h0, RESP_SLVERR);
    axi_write(OFS_STATUS, 32'h1f, RESP_OKAY);
    random_mix(8);
    $display("Test key_guard done");
    cfg(1'b0, 5'h0c, 5'h17, 16'h6135);
    random_mix(8);
    cfg(1'b1, 5'h0c, 5'h17, 16'h6135);
    axi_read(OFS_SEG, 32'h1f1f, 32'h170c, RESP_OKAY);
    foreach (edges[i])
      for (int k = 0; k < 3; k++)
        mem_access(edges[i], access_t'(k), 4'h0);
    drain();
    random_mix(40);
    $display("Test three_segments done");
    cfg(1'b1, 5'h10, 5'h10, 16'h5137);
    mem_access(16'hdfff, ACC_WRITE, 4'h0);
    mem_access(16'he000, ACC_WRITE, 4'h1);
    random_mix(30);
    cfg(1'b1, 5'h18, 5'h08, 16'h3561);
    random_mix(16);
    cfg(1'b0, 5'h18, 5'h08, 16'h0000);
    random_mix(12);
    $display("Test equal_and_disable done");
    cfg(1'b1, 5'h04, 5'h1c, 16'h0000);
    random_mix(8);
    mem_access(16'h1900, ACC_FETCH, 4'h0);
    drain();
    axi_read(OFS_VADDR, 32'hffff, 32'h1900, RESP_OKAY);
    axi_read(OFS_STATUS, 32'h8, 32'h8, RESP_OKAY);
    wstrb <= 4'h3;
    axi_write(OFS_CTL, {KEY_VALUE, 24'h0}, RESP_SLVERR);
    wstrb <= STRB_FULL;
    axi_read(OFS_CTL, 32'h1, 32'h1, RESP_OKAY);
    axi_write(OFS_STATUS, 32'h1f, RESP_OKAY);
    axi_read(OFS_STATUS, 32'h1f, 32'h0, RESP_OKAY);
    @(posedge clk);
    do_reset();
    $display("Test mid_reset done");
    tally_and_finish();
  end
endmodule : tb
